// *** ssa_pkg.sv ***
// Behaviour
// - Carrier-detect rise latches status bit 2 until status+data read or receiver reset.
// - Clear-to-send rise latches status bit 3 until clear command or transmitter reset.
// - Underflow in sync-fill mode sets status bit 4; cleared by command or reset.
// - Underflow sends sync code or all ones; underflow pulse only in sync-fill mode.
// - Character arriving into full receive buffer sets status bit 5.
// - Overrunning characters overwrite the first receive stage.
// - Status bit 6 marks parity error of last receive stage character.
// - Carrier-detect activity never clears parity or receive buffer status.
// - Status bit 7 equals active interrupt output under the same enables.
// - Interrupt flag clears once all enabled causing sources are cleared.
// - Receive buffer is three 8-bit stages shifting toward output each cycle.
// - Unused bits of short words read as zero from the receive buffer.
// - Transmit buffer is three shifting stages.
// - Status register is 8 bits, read-only; reading it arms the clear of bits 2 and 5 by a following data read.
// - Data available from last stage, or last two stages in two-byte mode.
// - Transmit available when first stage empty, or first two in two-byte mode, unless transmitter reset or clear-to-send high without external sync.
// - Control one bits 7,6 select registers; bits 5,4 enable receive, transmit irq.
// - Control one bit 3 clears receive sync; bit 2 strips sync codes.
// - Control one bit 1 resets transmitter; bit 0 resets receiver.
// - Control three bit 1 selects one-sync mode; bit 0 selects external sync.
// - Control three bit 3 clears underflow; bit 2 clears clear-to-send status.
// - Error enable makes overrun, underflow, parity error, carrier-detect or clear-to-send status raise the interrupt.
package ssa_pkg;
  localparam logic [2:0] AC_CTRL_TWO = 3'h0;
  localparam logic [1:0] AC_CTRL_THREE = 2'h1;
  localparam logic [1:0] AC_SYNC_CODE = 2'h2;
  localparam logic [1:0] AC_CTRL_TWO_SEL = 2'h0;
  localparam int C1_RECEIVER_RESET_BIT = 0;
  localparam int C1_TRANSMITTER_RESET_BIT = 1;
  localparam int C1_STRIP = 2;
  localparam int C1_CLR_SYNC = 3;
  localparam int C1_TIE = 4;
  localparam int C1_RIE = 5;
  localparam int C1_AC_LO = 6;
  localparam int C2_TWO_BYTE = 2;
  localparam int C2_WS_LO = 3;
  localparam int C2_TX_SYNC = 6;
  localparam int C2_EIE = 7;
  localparam int C3_EXT_SYNC = 0;
  localparam int C3_ONE_SYNC = 1;
  localparam int C3_CLR_CTS = 2;
  localparam int C3_CLEAR_UNDERFLOW_CMD = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] C1_RESET = 8'h03;
  localparam logic [7:0] MARK_CHAR = 8'hff;
endpackage : ssa_pkg

// *** sync_serial_adapter.sv ***
`timescale 1ns/1ps
module sync_serial_adapter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Parallel bus.
  input wire logic cs,
  input wire logic rs,
  input wire logic rd_wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Modem inputs.
  input wire logic dcd,
  input wire logic cts,
  // Serial side on the link clock.
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_bad,
  input wire logic tx_char_req,
  output logic [7:0] tx_char,
  output logic tx_fill,
  output logic underflow_out,
  // Interrupt and mode outputs.
  output logic irq_n,
  output logic clear_sync,
  output logic strip_sync,
  output logic one_sync_mode,
  output logic ext_sync_mode,
  output logic [7:0] sync_code,
  output logic [2:0] word_select
);
  import ssa_pkg::*;

  logic [7:0] c1_r, c2_r;
  logic [3:0] c3_r;
  logic [1:0] dcd_s, cts_s;
  logic dcd_d_r, cts_d_r, dcd_st_r, cts_st_r, tuf_r, ovrn_r, stat_rd_r;
  logic [7:0] rx_d [3];
  logic [2:0] rx_f;
  logic [2:0] rx_pe;
  logic [7:0] tx_d [3];
  logic [2:0] tx_f;
  logic [7:0] sync_r;
  logic [2:0] rxt_s, uft_s;
  logic rxt_r, txt_l, ack_l, uft_l;
  logic [7:0] rx_hold_l;
  logic rx_pe_hold_l;
  logic [7:0] tx_hold_r;
  logic [2:0] ack_s;
  logic tx_busy_r, tx_hold_full_l;

  wire wr = cs && !rd_wr;
  wire rd = cs && rd_wr;
  wire [1:0] ac = c1_r[C1_AC_LO +: 2];
  wire receiver_reset_bit = c1_r[C1_RECEIVER_RESET_BIT];
  wire transmitter_reset_bit = c1_r[C1_TRANSMITTER_RESET_BIT];
  wire two_byte = c2_r[C2_TWO_BYTE];
  wire rd_stat = rd && !rs;
  wire rd_data = rd && rs;
  wire wr_tx = wr && rs && ac == AC_CTRL_TWO_SEL + 2'h3;
  wire rx_evt = rxt_s[2] ^ rxt_s[1];
  wire uf_evt = uft_s[2] ^ uft_s[1];

  // Control registers; command bits of control three self-clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_r <= C1_RESET;
      c2_r <= RESET_BYTE;
      c3_r <= 4'h0;
      sync_r <= RESET_BYTE;
    end else begin
      c3_r[C3_CLR_CTS] <= 1'b0;
      c3_r[C3_CLEAR_UNDERFLOW_CMD] <= 1'b0;
      if (wr && !rs) begin
        c1_r <= wdata;
      end else if (wr && rs) begin
        case (ac)
          AC_CTRL_TWO_SEL: c2_r <= wdata;
          AC_CTRL_THREE: c3_r <= wdata[3:0];
          AC_SYNC_CODE: sync_r <= wdata;
          default: ;
        endcase
      end
    end
  end

  // Modem input synchronisers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dcd_s <= 2'h0;
      cts_s <= 2'h0;
      dcd_d_r <= 1'b0;
      cts_d_r <= 1'b0;
    end else begin
      dcd_s <= {dcd_s[0], dcd};
      cts_s <= {cts_s[0], cts};
      dcd_d_r <= dcd_s[1];
      cts_d_r <= cts_s[1];
    end
  end

  wire dcd_rise = dcd_s[1] && !dcd_d_r;
  wire cts_rise = cts_s[1] && !cts_d_r;
  wire rd_pair_clr = rd_data && stat_rd_r;
  wire rx_pop = rd_data && rx_f[2];
  // Stage 0 can only be overrun when none of the stages can move this cycle.
  wire rx_full = rx_f[0] && rx_f[1] && rx_f[2] && !rx_pop;

  // Latched status bits; a new event wins over a clear, except that section resets win for underflow and overrun.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dcd_st_r <= 1'b0;
      cts_st_r <= 1'b0;
      tuf_r <= 1'b0;
      ovrn_r <= 1'b0;
      stat_rd_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        stat_rd_r <= 1'b1;
      end else if (rd_data) begin
        stat_rd_r <= 1'b0;
      end
      if (dcd_rise) begin
        dcd_st_r <= 1'b1;
      end else if (rd_pair_clr || receiver_reset_bit) begin
        dcd_st_r <= 1'b0;
      end
      if (cts_rise) begin
        cts_st_r <= 1'b1;
      end else if (c3_r[C3_CLR_CTS] || transmitter_reset_bit) begin
        cts_st_r <= 1'b0;
      end
      if (uf_evt && c2_r[C2_TX_SYNC] && !transmitter_reset_bit) begin
        tuf_r <= 1'b1;
      end else if (c3_r[C3_CLEAR_UNDERFLOW_CMD] || transmitter_reset_bit) begin
        tuf_r <= 1'b0;
      end
      if (rx_evt && rx_full && !receiver_reset_bit) begin
        ovrn_r <= 1'b1;
      end else if (rd_pair_clr || receiver_reset_bit) begin
        ovrn_r <= 1'b0;
      end
    end
  end

  // Receive buffer stages shift toward stage 2 each cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_f <= 3'h0;
      rx_pe <= 3'h0;
      for (int i = 0; i < 3; i++) rx_d[i] <= RESET_BYTE;
    end else if (receiver_reset_bit) begin
      rx_f <= 3'h0;
      rx_pe <= 3'h0;
    end else begin
      if (rx_f[2] && !rx_pop) begin
        rx_f[2] <= 1'b1;
      end else if (rx_f[1]) begin
        rx_d[2] <= rx_d[1];
        rx_pe[2] <= rx_pe[1];
        rx_f[2] <= 1'b1;
      end else begin
        rx_f[2] <= 1'b0;
        rx_pe[2] <= 1'b0;
      end
      if (rx_f[1] && !(!rx_f[2] || rx_pop)) begin
        rx_f[1] <= 1'b1;
      end else if (rx_f[0]) begin
        rx_d[1] <= rx_d[0];
        rx_pe[1] <= rx_pe[0];
        rx_f[1] <= 1'b1;
      end else begin
        rx_f[1] <= 1'b0;
      end
      if (rx_evt) begin
        rx_d[0] <= rx_hold_l;
        rx_pe[0] <= rx_pe_hold_l;
        rx_f[0] <= 1'b1;
      end else if (rx_f[0] && !(rx_f[1] && !(!rx_f[2] || rx_pop))) begin
        rx_f[0] <= 1'b0;
      end
    end
  end

  // Word length mask for unused receive bits.
  function automatic logic [7:0] len_mask(input logic [2:0] ws);
    logic [7:0] m;
    m = 8'hff;
    case (ws)
      3'h0, 3'h1: m = 8'h3f;
      3'h2, 3'h4, 3'h5: m = 8'h7f;
      default: m = 8'hff;
    endcase
    return m;
  endfunction : len_mask

  // Transmit buffer; stage 0 is loaded by the bus, stage 2 feeds the link.
  wire tx_take = tx_f[2] && !tx_busy_r && !transmitter_reset_bit;
  // Writing the transmitter reset bit empties the buffer once; loads may follow.
  wire tx_flush = wr && !rs && wdata[C1_TRANSMITTER_RESET_BIT];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_f <= 3'h0;
      for (int i = 0; i < 3; i++) tx_d[i] <= RESET_BYTE;
    end else if (tx_flush) begin
      tx_f <= 3'h0;
    end else begin
      if (tx_f[2] && !tx_take) begin
        tx_f[2] <= 1'b1;
      end else if (tx_f[1]) begin
        tx_d[2] <= tx_d[1];
        tx_f[2] <= 1'b1;
      end else begin
        tx_f[2] <= 1'b0;
      end
      if (tx_f[1] && !(!tx_f[2] || tx_take)) begin
        tx_f[1] <= 1'b1;
      end else if (tx_f[0]) begin
        tx_d[1] <= tx_d[0];
        tx_f[1] <= 1'b1;
      end else begin
        tx_f[1] <= 1'b0;
      end
      if (wr_tx && !tx_f[0]) begin
        tx_d[0] <= wdata & len_mask(c2_r[C2_WS_LO +: 3]);
        tx_f[0] <= 1'b1;
      end else if (tx_f[0] && !(tx_f[1] && !(!tx_f[2] || tx_take))) begin
        tx_f[0] <= 1'b0;
      end
    end
  end

  // Hand-off of one transmit byte to the link by toggle handshake.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s <= 3'h0;
      tx_busy_r <= 1'b0;
      txt_l <= 1'b0;
      tx_hold_r <= RESET_BYTE;
      rxt_s <= 3'h0;
      uft_s <= 3'h0;
    end else begin
      ack_s <= {ack_s[1:0], ack_l};
      rxt_s <= {rxt_s[1:0], rxt_r};
      uft_s <= {uft_s[1:0], uft_l};
      if (tx_take) begin
        tx_hold_r <= tx_d[2];
        tx_busy_r <= 1'b1;
        txt_l <= ~txt_l;
      end else if (ack_s[2] ^ ack_s[1]) begin
        tx_busy_r <= 1'b0;
      end
    end
  end

  // Link side: receive capture, transmit selection and underflow pulse.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rxt_r <= 1'b0;
      rx_hold_l <= RESET_BYTE;
      rx_pe_hold_l <= 1'b0;
    end else if (rx_char_valid) begin
      rx_hold_l <= rx_char & len_mask(c2_r[C2_WS_LO +: 3]);
      rx_pe_hold_l <= rx_parity_bad && c2_r[C2_WS_LO +: 3] != 3'h2
        && c2_r[C2_WS_LO +: 3] != 3'h3;
      rxt_r <= ~rxt_r;
    end
  end

  logic [2:0] txs_l;
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      txs_l <= 3'h0;
      ack_l <= 1'b0;
      uft_l <= 1'b0;
      tx_hold_full_l <= 1'b0;
      tx_char <= MARK_CHAR;
      tx_fill <= 1'b0;
      underflow_out <= 1'b0;
    end else begin
      txs_l <= {txs_l[1:0], txt_l};
      underflow_out <= 1'b0;
      if (txs_l[2] ^ txs_l[1]) begin
        tx_hold_full_l <= 1'b1;
        ack_l <= ~ack_l;
      end
      if (tx_char_req) begin
        if (tx_hold_full_l) begin
          tx_char <= tx_hold_r;
          tx_fill <= 1'b0;
          tx_hold_full_l <= 1'b0;
        end else begin
          tx_char <= c2_r[C2_TX_SYNC] ? sync_r : MARK_CHAR;
          tx_fill <= 1'b1;
          uft_l <= ~uft_l;
          underflow_out <= c2_r[C2_TX_SYNC];
        end
      end
    end
  end

  // Status assembly and interrupt.
  wire receive_data_available = two_byte ? (rx_f[2] && rx_f[1]) : rx_f[2];
  wire transmit_register_available_raw = two_byte ? (!tx_f[0] && !tx_f[1]) : !tx_f[0];
  wire transmit_register_available = transmit_register_available_raw && !transmitter_reset_bit && !(cts_s[1] && !c3_r[C3_EXT_SYNC]);
  wire error_irq_enable = c2_r[C2_EIE];
  wire irq = (c1_r[C1_RIE] && receive_data_available) || (c1_r[C1_TIE] && transmit_register_available)
    || (error_irq_enable && (ovrn_r || tuf_r || rx_pe[2] || dcd_st_r || cts_st_r));
  wire dcd_bit = dcd_st_r || dcd_s[1];
  wire cts_bit = cts_st_r || cts_s[1];
  wire [7:0] status = {irq, rx_pe[2], ovrn_r, tuf_r, cts_bit, dcd_bit, transmit_register_available, receive_data_available};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= RESET_BYTE;
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~irq;
      if (rd_stat) begin
        rdata <= status;
      end else if (rd_data) begin
        rdata <= rx_d[2];
      end
    end
  end

  assign clear_sync = c1_r[C1_CLR_SYNC];
  assign strip_sync = c1_r[C1_STRIP];
  assign one_sync_mode = c3_r[C3_ONE_SYNC];
  assign ext_sync_mode = c3_r[C3_EXT_SYNC];
  assign sync_code = sync_r;
  assign word_select = c2_r[C2_WS_LO +: 3];
endmodule : sync_serial_adapter

// *** ssa_asserts.sv ***
`timescale 1ns/1ps
module ssa_asserts (
  // Bus side.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs,
  input wire logic rs,
  input wire logic rd_wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic irq_n,
  // Mode levels.
  input wire logic clear_sync,
  input wire logic strip_sync,
  input wire logic one_sync_mode,
  input wire logic ext_sync_mode,
  input wire logic [7:0] sync_code,
  input wire logic [2:0] word_select,
  // Link side.
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic [7:0] tx_char,
  input wire logic tx_fill,
  input wire logic underflow_out
);
  logic [7:0] c1_r;
  logic st_rd;
  assign st_rd = cs && !rs && rd_wr;
  // Shadow of control one, so access bits and section resets are known.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) c1_r <= 8'h03;
    else if (cs && !rs && !rd_wr) c1_r <= wdata;
  end
  AST_SYNC_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
    cs && !rs && !rd_wr |=> clear_sync == $past(wdata[3]) && strip_sync == $past(wdata[2]))
    else $error("sync control levels wrong");
  AST_CTRL_THREE: assert property (@(posedge clk) disable iff (!rst_n)
    cs && rs && !rd_wr && c1_r[7:6] == 2'h1
    |=> one_sync_mode == $past(wdata[1]) && ext_sync_mode == $past(wdata[0]))
    else $error("sync mode levels wrong");
  AST_TX_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    st_rd && c1_r[1] && $past(c1_r[1]) |=> !rdata[1])
    else $error("transmit available while held");
  AST_RX_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    st_rd && c1_r[0] && $past(c1_r[0]) |=> !rdata[0] && !rdata[5])
    else $error("receive status while held");
  AST_IRQ_BIT: assert property (@(posedge clk) disable iff (!rst_n)
    st_rd |=> rdata[7] != irq_n)
    else $error("status bit 7 disagrees with irq output");
  AST_SHORT_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    cs && rs && rd_wr && word_select <= 3'h1 |=> rdata[7:6] == 2'h0)
    else $error("unused bits not zero");
  AST_UF_PULSE: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    underflow_out |=> !underflow_out)
    else $error("underflow pulse too long");
  AST_FILL_CHAR: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    tx_fill |-> tx_char == sync_code || tx_char == 8'hff)
    else $error("fill character wrong");
endmodule : ssa_asserts
bind sync_serial_adapter ssa_asserts i_ssa_asserts (.clk, .rst_n, .cs, .rs, .rd_wr, .wdata,
  .rdata, .irq_n, .clear_sync, .strip_sync, .one_sync_mode, .ext_sync_mode, .sync_code,
  .word_select, .link_clk, .link_rst_n, .tx_char, .tx_fill, .underflow_out);

// *** ssa_link_model.sv ***
`timescale 1ns/1ps
module ssa_link_model (
  // Link clock.
  input wire logic link_clk,
  // Receive feed.
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic rx_parity_bad,
  // Transmit pull.
  output logic tx_char_req,
  input wire logic [7:0] tx_char,
  input wire logic tx_fill
);
  logic [8:0] got;
  event got_ev;
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_parity_bad = 1'b0;
    tx_char_req = 1'b0;
  end
  // Hands one character over; the data lines show garbage outside the pulse.
  task automatic send(input logic [7:0] ch, input logic pe);
    @(posedge link_clk);
    rx_char_valid <= 1'b1;
    rx_char <= ch;
    rx_parity_bad <= pe;
    @(posedge link_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~ch;
    rx_parity_bad <= ~pe;
    repeat (2) @(posedge link_clk);
  endtask : send
  // Asks for the next character and captures what the adapter offers.
  task automatic pull();
    @(posedge link_clk);
    tx_char_req <= 1'b1;
    @(posedge link_clk);
    tx_char_req <= 1'b0;
    @(negedge link_clk);
    @(negedge link_clk);
    got = {tx_fill, tx_char};
    ->got_ev;
  endtask : pull
endmodule : ssa_link_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk, link_clk, rst_n, cs, rs, rd_wr, dcd, cts, rd_q;
  logic [7:0] wdata, rdata, s;
  logic [7:0] c [4];
  logic [31:0] seed;
  logic [17:0] exp_q [$];
  int fail_count, check_count;
  wire logic rx_char_valid, rx_parity_bad, tx_char_req, tx_fill;
  wire logic [7:0] rx_char, tx_char;
  sync_serial_adapter i_sync_serial_adapter (.clk, .rst_n, .cs, .rs, .rd_wr, .wdata,
    .rdata, .dcd, .cts, .link_clk, .link_rst_n(rst_n), .rx_char_valid, .rx_char,
    .rx_parity_bad, .tx_char_req, .tx_char, .tx_fill, .underflow_out(), .irq_n(),
    .clear_sync(), .strip_sync(), .one_sync_mode(), .ext_sync_mode(), .sync_code(),
    .word_select());
  ssa_link_model i_ssa_link_model (.link_clk, .rx_char_valid, .rx_char, .rx_parity_bad,
    .tx_char_req, .tx_char, .tx_fill);
  always #4 clk = ~clk;
  always #62.5 link_clk = ~link_clk;
  function automatic logic [7:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : nxt
  task automatic acc(input logic r, input logic w, input logic [7:0] d);
    @(posedge clk);
    cs <= 1'b1;
    rs <= r;
    rd_wr <= w;
    wdata <= d;
    @(posedge clk);
    cs <= 1'b0;
  endtask : acc
  task automatic rd(input logic r, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({1'b0, m, 1'b0, e});
    acc(r, 1'b1, 8'h00);
    repeat (6) @(posedge clk);
  endtask : rd
  task automatic pause();
    repeat (30) @(posedge clk);
  endtask : pause
  task automatic cmp(input logic [8:0] got);
    logic [17:0] e;
    e = exp_q.pop_front();
    check_count++;
    if ((got & e[17:9]) !== e[8:0]) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h mask %h", $time, got, e[8:0], e[17:9]);
    end
  endtask : cmp
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Read results appear the cycle after the access is taken.
  always @(posedge clk) rd_q <= cs && rd_wr;
  always @(negedge clk) if (rd_q === 1'b1) cmp({1'b0, rdata});
  always @(i_ssa_link_model.got_ev) cmp(i_ssa_link_model.got);
  initial begin
    #100us;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    {clk, link_clk, rst_n, cs, rs, rd_wr, dcd, cts} = 8'h00;
    wdata = 8'h00;
    seed = 32'h452a2c5a;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(1'b0, 8'hff, 8'h00);
    acc(1'b0, 1'b0, 8'h00);
    acc(1'b1, 1'b0, 8'h98);
    pause();
    rd(1'b0, 8'h02, 8'h02);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      c[i] = nxt();
      i_ssa_link_model.send(c[i], 1'b0);
    end
    pause();
    rd(1'b0, 8'he1, 8'ha1);
    rd(1'b1, 8'hff, c[0]);
    rd(1'b1, 8'hff, c[1]);
    rd(1'b1, 8'hff, c[3]);
    rd(1'b0, 8'he1, 8'h00);
    $display("overrun test done");
    acc(1'b1, 1'b0, 8'h80);
    c[0] = nxt();
    dcd <= 1'b1;
    pause();
    dcd <= 1'b0;
    i_ssa_link_model.send(c[0], 1'b1);
    pause();
    rd(1'b0, 8'hc5, 8'hc5);
    rd(1'b1, 8'hff, {2'b00, c[0][5:0]});
    rd(1'b0, 8'hc5, 8'h00);
    $display("parity test done");
    acc(1'b1, 1'b0, 8'hd8);
    acc(1'b0, 1'b0, 8'h80);
    s = nxt();
    acc(1'b1, 1'b0, s);
    cts <= 1'b1;
    pause();
    cts <= 1'b0;
    pause();
    rd(1'b0, 8'h08, 8'h08);
    acc(1'b0, 1'b0, 8'h40);
    acc(1'b1, 1'b0, 8'h06);
    rd(1'b0, 8'h88, 8'h00);
    exp_q.push_back({9'h1ff, 1'b1, s});
    i_ssa_link_model.pull();
    pause();
    rd(1'b0, 8'h90, 8'h90);
    acc(1'b1, 1'b0, 8'h08);
    rd(1'b0, 8'h90, 8'h00);
    acc(1'b0, 1'b0, 8'hc0);
    c[0] = nxt();
    acc(1'b1, 1'b0, c[0]);
    repeat (2) pause();
    exp_q.push_back({9'h1ff, 1'b0, c[0]});
    i_ssa_link_model.pull();
    pause();
    $display("transmit test done");
    acc(1'b0, 1'b0, 8'h00);
    acc(1'b1, 1'b0, 8'h1c);
    c[0] = nxt();
    c[1] = nxt();
    i_ssa_link_model.send(c[0], 1'b0);
    pause();
    rd(1'b0, 8'h01, 8'h00);
    i_ssa_link_model.send(c[1], 1'b0);
    pause();
    rd(1'b0, 8'h01, 8'h01);
    rd(1'b1, 8'hff, c[0]);
    acc(1'b1, 1'b0, 8'h18);
    rd(1'b0, 8'h01, 8'h01);
    acc(1'b0, 1'b0, 8'h01);
    rd(1'b0, 8'h01, 8'h00);
    $display("receive reset test done");
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("[FAIL] %0t unanswered expectations %0d", $time, exp_q.size());
    end
    print_verdict();
  end
endmodule : testbench
